// ===== ddrs_host.sv
// host controller model driving the sram pins
// assumes the bench calls op() and merges dq_drv onto dq_in
`timescale 1ns/100ps

module ddrs_host (
  output logic        primary_clk,
  output logic [1:0]  write_data_clk,
  output logic        load_n,
  output logic        rw_sel,
  output logic [20:0] addr_in,
  output logic [35:0] dq_drv
);
  // ****
  // free-running primary clock
  // ****
  initial begin
    primary_clk = 1'b0;
    write_data_clk = 2'h0;
    load_n = 1'b1;
    rw_sel = 1'b1;
    addr_in = 21'h0;
    dq_drv = 36'h0;
    #13;
    forever #200 primary_clk = ~primary_clk;
  end

  // one command; write clocks run only for write beats
  task automatic op(input logic rd, input logic [20:0] a, input logic [71:0] d);
    @(negedge primary_clk);
    load_n <= 1'b0;
    rw_sel <= rd;
    addr_in <= a;
    @(posedge primary_clk);
    if (!rd) begin
      dq_drv = d[35:0];
    end
    // command held a quarter period past the rise, so the sampled rise still sees it
    #100;
    load_n <= 1'b1;
    addr_in <= ~a; // released lines show inverse
    if (!rd) begin
      write_data_clk = 2'h3;
      fork
        begin
          #100 dq_drv = d[71:36];
          #100 write_data_clk = 2'h0;
          #50 dq_drv = ~d[71:36];
        end
      join_none
    end
  endtask
endmodule

// ===== ddrs_map.svh
// constants for the ddr burst-of-two sram pin block: offsets, fields, codes
// assumes inclusion by bare name from the package and the design module
`ifndef DDRS_MAP_SVH
`define DDRS_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define DDRS_OFF_CTRL    8'h00
`define DDRS_OFF_STATUS  8'h04
`define DDRS_OFF_RD_CNT  8'h08
`define DDRS_OFF_WR_CNT  8'h0c

// ************************************************************
// field positions and reset values
// ************************************************************
`define DDRS_CTRL_HOLD_BIT   0
`define DDRS_CTRL_RESET      32'h0000_0000
`define DDRS_ST_PLL_BIT      0
`define DDRS_ST_RST_BIT      1
`define DDRS_ST_RDSEEN_BIT   2
`define DDRS_ST_MODE_LSB     4
`define DDRS_ST_GROUP_LSB    6

// ************************************************************
// pin codes and timing
// ************************************************************
`define DDRS_MODE_OFF     2'h0
`define DDRS_MODE_STRONG  2'h1
`define DDRS_MODE_WEAK    2'h2
`define DDRS_RD_LATENCY   3
`define DDRS_SYNC_STAGES  2

`endif

// ===== ddrs_pkg.sv
// types for the ddr burst-of-two sram pin block
// assumes the constants header sits in the same folder
package ddrs_pkg;
  `include "ddrs_map.svh"

  // all pins arriving from outside, sampled together
  typedef struct packed {
    logic        ck;
    logic [1:0]  kd;
    logic        load_n;
    logic        rw_sel;
    logic [20:0] addr;
    logic [35:0] dq;
    logic        pll_en;
    logic        rst;
    logic [1:0]  odt_mode;
    logic [1:0]  odt_group;
  } ddrs_pins_t;

  // one accepted access in the read pipeline
  typedef struct packed {
    logic        valid;
    logic [20:0] addr;
  } ddrs_cmd_t;

  // write capture per data group
  typedef enum logic [1:0] {
    DDRS_WS_IDLE = 2'b01,
    DDRS_WS_HIGH = 2'b10
  } ddrs_wstate_t;
endpackage

// ===== ddrs_sram.sv
// ddr burst-of-two common-i/o sram pin behaviour, sampled on hclk
// assumes every pin is asynchronous to hclk and slower than hclk / 4
//
// What this block does
// - address captured on primary clock rise
// - writes on write clock edges, reads on echo
// - x18 uses bits 17..0, x36 all
// - read valid rises half cycle early
// - write clock 0 takes lower group
// - write clock 1 takes upper group
// - echo clocks run free, aligned with data
// - echo pair per data group
// - primary clock times inputs and outputs
// - load low accepts address, starts access
// - load high is a no-operation
// - read/write low starts a write
// - read/write high starts a read
// - pll enable pin switches the pll
// - reset pin holds device inactive
// - mode strap picks off, strong, weak
// - group strap picks terminated groups
// - reset disables pll, ignores controls
// - bus idle, valid low until first read
`timescale 1ns/100ps
`include "ddrs_map.svh"

module ddrs_sram
  import ddrs_pkg::*;
#(
  parameter int WIDE   = 1,
  parameter int MEM_AW = 6
) (
  input  logic        hclk,
  input  logic        hresetn,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic [31:0] hrdata,
  output logic        hreadyout,
  output logic        hresp,
  input  logic        primary_clk,
  input  logic [1:0]  write_data_clk,
  input  logic        load_n,
  input  logic        rw_sel,
  input  logic [20:0] addr_in,
  input  logic        pll_en,
  input  logic        rst,
  input  logic [1:0]  odt_mode_sel,
  input  logic [1:0]  odt_group_sel,
  input  logic [35:0] dq_in,
  output logic [35:0] dq_out,
  output logic [35:0] dq_oe,
  output logic [1:0]  echo_clk,
  output logic [1:0]  echo_clk_n,
  output logic [1:0]  read_valid_out,
  output logic        pll_on,
  output logic        odt_on_data,
  output logic        odt_on_clk,
  output logic        odt_on_ctl,
  output logic        odt_strong
);

  localparam int GW    = (WIDE != 0) ? 18 : 9;
  localparam int MEM_D = 1 << MEM_AW;

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  ddrs_pins_t pin_s1;
  ddrs_pins_t pin_s2;
  logic       ck_d;
  logic [1:0] kd_d;
  logic       ck_rise;
  logic       ck_fall;
  logic [1:0] kd_rise;
  logic [1:0] kd_fall;

  // two flops on every outside pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= '{ck: primary_clk, kd: write_data_clk, load_n: load_n, rw_sel: rw_sel,
                  addr: addr_in, dq: dq_in, pll_en: pll_en, rst: rst,
                  odt_mode: odt_mode_sel, odt_group: odt_group_sel};
      pin_s2 <= pin_s1;
    end
  end

  // delayed clocks for edge finding
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_d <= 1'b0;
      kd_d <= 2'h0;
    end else begin
      ck_d <= pin_s2.ck;
      kd_d <= pin_s2.kd;
    end
  end

  assign ck_rise = pin_s2.ck & ~ck_d;
  assign ck_fall = ~pin_s2.ck & ck_d;
  assign kd_rise = pin_s2.kd & ~kd_d;
  assign kd_fall = ~pin_s2.kd & kd_d;

  // ************************************************************
  // register bus slave
  // ************************************************************
  logic [31:0] ctrl;
  logic [31:0] rd_cnt;
  logic [31:0] wr_cnt;
  logic        read_seen;
  logic        bus_wr;
  logic [7:0]  bus_wa;
  logic        take;
  logic [31:0] status;
  logic        dev_active;

  assign take = hsel & hready & htrans[1];
  assign status = {24'h0, pin_s2.odt_group, pin_s2.odt_mode, 1'b0, read_seen,
                   pin_s2.rst, pll_on};

  // zero-wait answers, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      bus_wr    <= 1'b0;
      bus_wa    <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      bus_wr    <= take & hwrite;
      bus_wa    <= haddr[7:0];
      if (take && !hwrite) begin
        case (haddr[7:0])
          `DDRS_OFF_CTRL:   hrdata <= ctrl;
          `DDRS_OFF_STATUS: hrdata <= status;
          `DDRS_OFF_RD_CNT: hrdata <= rd_cnt;
          `DDRS_OFF_WR_CNT: hrdata <= wr_cnt;
          default:          hrdata <= 32'h0;
        endcase
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `DDRS_CTRL_RESET;
    end else if (bus_wr && bus_wa == `DDRS_OFF_CTRL) begin
      ctrl <= {31'h0, hwdata[`DDRS_CTRL_HOLD_BIT]};
    end
  end

  // pin reset or software hold both idle the device
  assign dev_active = ~pin_s2.rst & ~ctrl[`DDRS_CTRL_HOLD_BIT];

  // ************************************************************
  // straps: pll and termination
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_on      <= 1'b0;
      odt_on_data <= 1'b0;
      odt_on_clk  <= 1'b0;
      odt_on_ctl  <= 1'b0;
      odt_strong  <= 1'b0;
    end else begin
      pll_on <= pin_s2.pll_en & ~pin_s2.rst;
      // reserved mode code treated as off
      odt_on_data <= (pin_s2.odt_mode == `DDRS_MODE_STRONG) ||
                     (pin_s2.odt_mode == `DDRS_MODE_WEAK);
      odt_on_clk  <= ((pin_s2.odt_mode == `DDRS_MODE_STRONG) ||
                      (pin_s2.odt_mode == `DDRS_MODE_WEAK)) & pin_s2.odt_group[0];
      odt_on_ctl  <= ((pin_s2.odt_mode == `DDRS_MODE_STRONG) ||
                      (pin_s2.odt_mode == `DDRS_MODE_WEAK)) & pin_s2.odt_group[1];
      odt_strong  <= (pin_s2.odt_mode == `DDRS_MODE_STRONG);
    end
  end

  // ************************************************************
  // command decode and read pipeline
  // ************************************************************
  ddrs_cmd_t wr_cmd;
  ddrs_cmd_t rd_pipe [`DDRS_RD_LATENCY];
  logic      accept;

  // load low with reset and software hold both idle accepts, load high is a nop
  assign accept = ck_rise & dev_active & ~pin_s2.load_n;

  // new write address for the capture logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cmd <= '0;
    end else if (ck_rise) begin
      wr_cmd <= '{valid: accept & ~pin_s2.rw_sel, addr: pin_s2.addr};
    end else begin
      wr_cmd.valid <= 1'b0;
    end
  end

  // three primary cycles of read latency
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `DDRS_RD_LATENCY; i++) begin
        rd_pipe[i] <= '0;
      end
    end else if (!dev_active) begin
      for (int i = 0; i < `DDRS_RD_LATENCY; i++) begin
        rd_pipe[i] <= '0;
      end
    end else if (ck_rise) begin
      rd_pipe[0] <= '{valid: accept & pin_s2.rw_sel, addr: pin_s2.addr};
      for (int i = 1; i < `DDRS_RD_LATENCY; i++) begin
        rd_pipe[i] <= rd_pipe[i-1];
      end
    end
  end

  // access counters and first-read flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt    <= 32'h0;
      wr_cnt    <= 32'h0;
      read_seen <= 1'b0;
    end else begin
      if (accept && pin_s2.rw_sel) begin
        rd_cnt <= rd_cnt + 32'h1;
      end
      if (accept && !pin_s2.rw_sel) begin
        wr_cnt <= wr_cnt + 32'h1;
      end
      if (ck_rise && rd_pipe[`DDRS_RD_LATENCY-1].valid) begin
        read_seen <= 1'b1;
      end
    end
  end

  // ************************************************************
  // per data group: write capture, storage, read drive, echo
  // ************************************************************
  for (genvar g = 0; g < 2; g++) begin : grp
    logic [2*GW-1:0] mem [MEM_D];
    ddrs_wstate_t    wstate;
    logic            wpend;
    logic [MEM_AW-1:0] waddr;
    logic [GW-1:0]   beat0;
    logic [GW-1:0]   rd_hi;
    logic            driving;

    // write clock g owns lane g of the data bus
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        wstate <= DDRS_WS_IDLE;
        wpend  <= 1'b0;
        waddr  <= '0;
        beat0  <= '0;
      end else begin
        if (wr_cmd.valid) begin
          wpend <= 1'b1;
          waddr <= wr_cmd.addr[MEM_AW-1:0];
        end
        case (wstate)
          DDRS_WS_IDLE: begin
            if (kd_rise[g] && wpend && !wr_cmd.valid) begin
              beat0  <= pin_s2.dq[g*GW +: GW];
              wpend  <= 1'b0;
              wstate <= DDRS_WS_HIGH;
            end
          end
          DDRS_WS_HIGH: begin
            if (kd_fall[g]) begin
              wstate <= DDRS_WS_IDLE;
            end
          end
          default: wstate <= DDRS_WS_IDLE;
        endcase
      end
    end

    // second beat commits the pair to the array
    always_ff @(posedge hclk) begin
      if (wstate == DDRS_WS_HIGH && kd_fall[g]) begin
        mem[waddr] <= {pin_s2.dq[g*GW +: GW], beat0};
      end
    end

    // beat 0 on echo rise, beat 1 on echo fall
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        driving <= 1'b0;
        rd_hi   <= '0;
        dq_out[g*GW +: GW] <= '0;
      end else if (!dev_active) begin
        driving <= 1'b0;
      end else if (ck_rise) begin
        driving <= rd_pipe[`DDRS_RD_LATENCY-1].valid;
        if (rd_pipe[`DDRS_RD_LATENCY-1].valid) begin
          dq_out[g*GW +: GW] <= mem[rd_pipe[`DDRS_RD_LATENCY-1].addr[MEM_AW-1:0]][GW-1:0];
          rd_hi <= mem[rd_pipe[`DDRS_RD_LATENCY-1].addr[MEM_AW-1:0]][2*GW-1:GW];
        end
      end else if (ck_fall && driving) begin
        dq_out[g*GW +: GW] <= rd_hi;
      end
    end

    assign dq_oe[g*GW +: GW] = {GW{driving}};

    // valid raised at the fall before the first beat
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        read_valid_out[g] <= 1'b0;
      end else if (!dev_active) begin
        read_valid_out[g] <= 1'b0;
      end else if (ck_fall) begin
        read_valid_out[g] <= rd_pipe[`DDRS_RD_LATENCY-1].valid;
      end
    end

    // echo follows primary clock on the same edge as data
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        echo_clk[g]   <= 1'b0;
        echo_clk_n[g] <= 1'b1;
      end else begin
        echo_clk[g]   <= pin_s2.ck;
        echo_clk_n[g] <= ~pin_s2.ck;
      end
    end
  end

  // x18 leaves the upper lanes undriven
  if (2 * GW < 36) begin : unused_lanes
    assign dq_out[35:2*GW] = '0;
    assign dq_oe[35:2*GW]  = '0;
  end

endmodule

// ===== ddrs_sram_properties.sv
// port assertions for the sram pin block
// assumes a 400 ns primary clock, eight hclk periods, x36
`timescale 1ns/100ps

module ddrs_sram_properties (
  input logic        hclk,
  input logic        hresetn,
  input logic        primary_clk,
  input logic        pll_en,
  input logic        rst,
  input logic [35:0] dq_oe,
  input logic [1:0]  echo_clk,
  input logic [1:0]  echo_clk_n,
  input logic [1:0]  read_valid_out,
  input logic        pll_on
);
  // ****
  // checks
  // ****
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  echo_inverse_a: assert property (echo_clk_n == ~echo_clk)
    else $error("echo pair not inverse");
  echo_follow_a: assert property ($rose(echo_clk[0]) |-> $past(primary_clk, 3))
    else $error("echo clock not from primary clock");
  echo_free_a: assert property ($rose(echo_clk[0]) |-> echo_clk[0][*4] ##1 !echo_clk[0])
    else $error("echo clock not free running");
  pll_follow_a: assert property ((pll_en && !rst)[*4] |=> pll_on)
    else $error("pll not on");
  pll_off_a: assert property ((!pll_en)[*4] |=> !pll_on)
    else $error("pll not off");
  reset_quiet_a: assert property (rst[*4] |=> !pll_on && dq_oe == 36'h0 && !read_valid_out)
    else $error("device active in reset");
  valid_lead_a: assert property ($rose(read_valid_out[0]) |-> ##4 $rose(dq_oe[0]))
    else $error("valid not half cycle early");
  drive_end_a: assert property ($fell(read_valid_out[0]) |-> ##4 $fell(dq_oe[0]))
    else $error("drive not ending after burst");
  group_even_a: assert property (dq_oe == {36{dq_oe[0]}} && echo_clk[1] == echo_clk[0])
    else $error("groups out of step");
endmodule

bind ddrs_sram ddrs_sram_properties i_props (.hclk, .hresetn, .primary_clk, .pll_en, .rst,
  .dq_oe, .echo_clk, .echo_clk_n, .read_valid_out, .pll_on);

// ===== testbench.sv
// self-checking bench for the sram pin block
// assumes the design, host model and checker are compiled first
`timescale 1ns/100ps

module testbench;
  logic        hclk, hresetn, hwrite, pll_en, rst, hreadyout, hresp, primary_clk;
  logic        load_n, rw_sel, pll_on, odt_on_data, odt_on_clk, odt_on_ctl, odt_strong;
  logic [1:0]  htrans, odt_mode_sel, odt_group_sel, write_data_clk, echo_clk;
  logic [1:0]  echo_clk_n, read_valid_out;
  logic [31:0] haddr, hwdata, hrdata, seed, v, n_wr, n_rd;
  logic [35:0] dq_in, dq_out, dq_oe, dq_drv;
  logic [20:0] addr_in, aq[$];
  logic [71:0] mem[64];
  int          n_mismatch, samples_checked;

  ddrs_sram i_ddrs_sram (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .primary_clk,
    .write_data_clk, .load_n, .rw_sel, .addr_in, .pll_en, .rst, .odt_mode_sel,
    .odt_group_sel, .dq_in, .dq_out, .dq_oe, .echo_clk, .echo_clk_n, .read_valid_out,
    .pll_on, .odt_on_data, .odt_on_clk, .odt_on_ctl, .odt_strong);
  ddrs_host i_ddrs_host (.primary_clk, .write_data_clk, .load_n, .rw_sel, .addr_in, .dq_drv);
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & dq_drv);

  // ****
  // helpers
  // ****
  always #25 hclk = ~hclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] odt_exp(input logic [1:0] m, input logic [1:0] g);
    logic on;
    on = (m == 2'h1) || (m == 2'h2);
    return {on, on & g[0], on & g[1], m == 2'h1};
  endfunction
  task automatic chk(input string s, input logic [71:0] e, input logic [71:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wait_rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    v = hrdata;
  endtask
  task automatic wr(input logic [20:0] a, input logic [71:0] d);
    i_ddrs_host.op(1'b0, a, d);
    mem[a[5:0]] = d;
    n_wr++;
  endtask
  task automatic rd_chk(input logic [20:0] q[$]);
    logic [35:0] b0;
    fork
      foreach (q[i]) i_ddrs_host.op(1'b1, q[i], 72'h0);
    join_none
    repeat (60) begin
      @(posedge hclk);
      if (read_valid_out[0] === 1'b1) break;
    end
    foreach (q[i]) begin
      repeat (i == 0 ? 5 : 4) @(posedge hclk);
      b0 = dq_out;
      repeat (4) @(posedge hclk);
      chk("read pair", mem[q[i][5:0]], {dq_out, b0});
    end
    n_rd += q.size();
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****
  // tests
  // ****
  initial begin
    {hclk, hresetn, hwrite, rst, htrans, haddr, hwdata, n_wr, n_rd} = '0;
    {pll_en, odt_mode_sel, odt_group_sel} = 5'h17;
    seed = 32'h34;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("idle bus", 72'h0, 72'({dq_oe, read_valid_out}));
    ahb(1'b0, 8'h04, 32'h0);
    chk("status", 72'hd1, 72'(v));
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 72'h0, 72'(v));
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 4; g++) begin
        odt_mode_sel <= 2'(m);
        odt_group_sel <= 2'(g);
        repeat (4) @(posedge hclk);
        chk("odt", 72'(odt_exp(2'(m), 2'(g))),
            72'({odt_on_data, odt_on_clk, odt_on_ctl, odt_strong}));
      end
    end
    $display("test straps done");
    wr(21'h1f_ffff, {72{1'b1}});
    aq.push_back(21'h1f_ffff);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      aq.push_back(seed[20:0]);
      seed = lfsr(seed);
      wr(aq[i + 1], {seed, ~seed, seed[7:0]});
    end
    rd_chk(aq);
    repeat (16) @(posedge hclk);
    chk("nop quiet", 72'h0, 72'({dq_oe, read_valid_out}));
    ahb(1'b0, 8'h0c, 32'h0);
    chk("write count", 72'(n_wr), 72'(v));
    ahb(1'b0, 8'h08, 32'h0);
    chk("read count", 72'(n_rd), 72'(v));
    $display("test burst done");
    ahb(1'b1, 8'h00, 32'h1);
    i_ddrs_host.op(1'b0, aq[1], 72'h0);
    ahb(1'b1, 8'h00, 32'h0);
    rd_chk({aq[1]});
    rst <= 1'b1;
    i_ddrs_host.op(1'b1, aq[2], 72'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk("status in reset", 72'h6, 72'(v[2:0]));
    rst <= 1'b0;
    repeat (5) @(posedge hclk);
    chk("pll on", 72'h1, 72'(pll_on));
    pll_en <= 1'b0;
    repeat (5) @(posedge hclk);
    chk("pll off", 72'h0, 72'(pll_on));
    pll_en <= 1'b1;
    ahb(1'b0, 8'h08, 32'h0);
    chk("reads in reset", 72'(n_rd), 72'(v));
    $display("test reset pin done");
    test_done;
  end

  // hang guard
  initial begin
    #300000;
    n_mismatch++;
    test_done;
  end
endmodule
